// ### src/vipb_pkg.sv
// Behaviour
// - The vector register points at the handler pointer slot of the active source.
// - First priority register holds flash, timer and software levels, three bits each.
// - Source 0 has no priority; bits 3 to 0 of the first register are empty.
// - Second priority register holds I2C, PLL lock, UART and converter levels.
// - Third priority register holds external pin, logic array, monitor, comparator, SPI.
// - Fourth priority register holds PWM in bits 6:4, logic array 1 in 2:0.
// - Nesting bit 0 enables priorities and nesting; clear means neither takes effect.
// - Vector bits 6:2 give the winning source index, bits 22:7 the base.
// - Reading the vector in nested mode with a source pending sets the in-service bit of its level.
package vipb_pkg;

  // Byte addresses of the register map.
  localparam logic [31:0] VIPB_ADDR_BASE = 32'hffff0014;
  localparam logic [31:0] VIPB_ADDR_VEC = 32'hffff001c;
  localparam logic [31:0] VIPB_ADDR_PRIO0 = 32'hffff0020;
  localparam logic [31:0] VIPB_ADDR_PRIO1 = 32'hffff0024;
  localparam logic [31:0] VIPB_ADDR_PRIO2 = 32'hffff0028;
  localparam logic [31:0] VIPB_ADDR_PRIO3 = 32'hffff002c;
  localparam logic [31:0] VIPB_ADDR_NEST = 32'hffff0030;
  localparam logic [31:0] VIPB_ADDR_INSVC = 32'hffff003c;

  // Writable bits of each priority register; all others are reserved.
  localparam logic [31:0] VIPB_MASK_PRIO0 = 32'h77777770;
  localparam logic [31:0] VIPB_MASK_PRIO1 = 32'h77777777;
  localparam logic [31:0] VIPB_MASK_PRIO2 = 32'h77777777;
  localparam logic [31:0] VIPB_MASK_PRIO3 = 32'h00000077;
  localparam logic [31:0] VIPB_RESET_VALUE = 32'h00000000;

  // Source count, level width, fields per register and field spacing.
  localparam int VIPB_NUM_SRC = 28;
  localparam int VIPB_LVL_W = 3;
  localparam int VIPB_NUM_LVL = 8;
  localparam int VIPB_FIELDS = 8;
  localparam int VIPB_FIELD_STEP = 4;
  localparam int VIPB_PRIO_SRC = 26;
  localparam int VIPB_NEST_BIT = 0;
  localparam int VIPB_WAIT_CYCLES = 1;

  typedef logic [VIPB_LVL_W-1:0] vipb_level_t;
  typedef logic [4:0] vipb_index_t;

  // Avalon-MM request as seen by the slave.
  typedef struct packed {
    logic read;
    logic write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } vipb_av_req_t;

  // Whole register state of the bank.
  typedef struct packed {
    logic [3:0][31:0] prio;
    logic [15:0] base;
    logic nest_en;
    logic [VIPB_NUM_LVL-1:0] in_service;
    logic ack;
    logic [31:0] rdata;
    logic vec_hit;
    vipb_level_t vec_level;
  } vipb_state_t;

endpackage

// ### src/vipb_resolve.sv
`timescale 1ns/1ps
module vipb_resolve
  import vipb_pkg::*;
(
  // Source requests and levels.
  input wire logic [VIPB_NUM_SRC-1:0] src_active,
  input wire logic [VIPB_NUM_SRC-1:0][VIPB_LVL_W-1:0] src_level,
  // Nesting state.
  input wire logic nest_en,
  input wire logic [VIPB_NUM_LVL-1:0] in_service,
  // Result.
  output logic hit,
  output vipb_index_t win_index,
  output vipb_level_t win_level
);

  logic [3:0] threshold;
  logic [VIPB_NUM_SRC-1:0] eligible;

  // Lowest set in-service bit blocks its own level and every higher-numbered one.
  always_comb begin
    threshold = 4'h8;
    for (int l = VIPB_NUM_LVL - 1; l >= 0; l--) begin
      if (in_service[l]) begin
        threshold = l[3:0];
      end
    end
  end

  // Per-source gate; without nesting nothing is blocked.
  genvar s;
  generate
    for (s = 0; s < VIPB_NUM_SRC; s++) begin : g_src
      assign eligible[s] = src_active[s] &&
        (!nest_en || ({1'b0, src_level[s]} < threshold));
    end
  endgenerate

  // Level 0 wins; ties go to the lower index. Priority is ignored when
  // nesting is off, so the lowest active index then wins.
  always_comb begin
    hit = 1'b0;
    win_index = 5'h0;
    win_level = 3'h0;
    for (int i = VIPB_NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!hit || !nest_en || src_level[i] <= win_level)) begin
        hit = 1'b1;
        win_index = i[4:0];
        win_level = src_level[i];
      end
    end
  end

endmodule

// ### src/vipb_bank.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module vipb_bank
  import vipb_pkg::*;
(
  // Clock and synchronous reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Avalon-MM slave.
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Enabled, pending IRQ sources, one bit per source index.
  input wire logic [VIPB_NUM_SRC-1:0] irq_active,
  // Arbitration result towards the core.
  output logic irq_request,
  output vipb_index_t irq_index,
  output logic irq_nesting_on
);

  vipb_state_t st_q;
  vipb_state_t st_d;
  vipb_av_req_t req;
  logic [VIPB_NUM_SRC-1:0][VIPB_LVL_W-1:0] src_level;
  logic hit;
  vipb_index_t win_index;
  vipb_level_t win_level;
  logic [31:0] wmask;
  logic [31:0] vec_word;
  logic [VIPB_NUM_LVL-1:0] lowest_insvc;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata, byteenable: avs_byteenable};

  // Each source s takes field s mod 8 of priority register s div 8.
  // Source 0 and the two sources past the fourth register sit at level 0.
  genvar s;
  generate
    for (s = 0; s < VIPB_NUM_SRC; s++) begin : g_lvl
      if (s == 0 || s >= VIPB_PRIO_SRC) begin : g_fixed
        assign src_level[s] = 3'h0;
      end else begin : g_prog
        assign src_level[s] = st_q.prio[s / VIPB_FIELDS]
          [(s % VIPB_FIELDS) * VIPB_FIELD_STEP +: VIPB_LVL_W];
      end
    end
  endgenerate

  vipb_resolve u_resolve (
    .src_active(irq_active),
    .src_level(src_level),
    .nest_en(st_q.nest_en),
    .in_service(st_q.in_service),
    .hit(hit),
    .win_index(win_index),
    .win_level(win_level)
  );

  // Byte lanes to a bit mask for writes.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{req.byteenable[b]}};
    end
  end

  // Vector word: base above the index, each slot a 32-bit pointer.
  assign vec_word = {9'h0, st_q.base, win_index, 2'b00};

  // One-hot of the highest-priority in-service level; only it may clear.
  assign lowest_insvc = st_q.in_service & (~st_q.in_service + 8'h01);

  // Access takes one wait cycle: data is prepared, then acknowledged.
  // Writes and read side effects land on the acknowledging edge.
  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    if ((req.read || req.write) && !st_q.ack) begin
      st_d.ack = 1'b1;
      st_d.rdata = 32'h00000000;
      st_d.vec_hit = 1'b0;
      st_d.vec_level = win_level;
      if (req.read) begin
        unique case (req.address)
          VIPB_ADDR_BASE: st_d.rdata = {16'h0000, st_q.base};
          VIPB_ADDR_VEC: begin
            st_d.rdata = vec_word;
            st_d.vec_hit = hit;
          end
          VIPB_ADDR_PRIO0: st_d.rdata = st_q.prio[0] & VIPB_MASK_PRIO0;
          VIPB_ADDR_PRIO1: st_d.rdata = st_q.prio[1] & VIPB_MASK_PRIO1;
          VIPB_ADDR_PRIO2: st_d.rdata = st_q.prio[2] & VIPB_MASK_PRIO2;
          VIPB_ADDR_PRIO3: st_d.rdata = st_q.prio[3] & VIPB_MASK_PRIO3;
          VIPB_ADDR_NEST: st_d.rdata = {31'h0, st_q.nest_en};
          VIPB_ADDR_INSVC: st_d.rdata = {24'h000000, st_q.in_service};
          default: st_d.rdata = 32'h00000000;
        endcase
      end
    end else if (st_q.ack && req.write) begin
      unique case (req.address)
        VIPB_ADDR_BASE:
          st_d.base = (st_q.base & ~wmask[15:0]) |
                      (req.writedata[15:0] & wmask[15:0]);
        VIPB_ADDR_PRIO0:
          st_d.prio[0] = (st_q.prio[0] & ~(wmask & VIPB_MASK_PRIO0)) |
            (req.writedata & wmask & VIPB_MASK_PRIO0);
        VIPB_ADDR_PRIO1:
          st_d.prio[1] = (st_q.prio[1] & ~(wmask & VIPB_MASK_PRIO1)) |
            (req.writedata & wmask & VIPB_MASK_PRIO1);
        VIPB_ADDR_PRIO2:
          st_d.prio[2] = (st_q.prio[2] & ~(wmask & VIPB_MASK_PRIO2)) |
            (req.writedata & wmask & VIPB_MASK_PRIO2);
        VIPB_ADDR_PRIO3:
          st_d.prio[3] = (st_q.prio[3] & ~(wmask & VIPB_MASK_PRIO3)) |
            (req.writedata & wmask & VIPB_MASK_PRIO3);
        VIPB_ADDR_NEST:
          if (req.byteenable[0]) begin
            st_d.nest_en = req.writedata[VIPB_NEST_BIT];
          end
        VIPB_ADDR_INSVC:
          // A one on the top in-service bit clears it, and only it.
          if (req.byteenable[0]) begin
            st_d.in_service = st_q.in_service &
              ~(lowest_insvc & req.writedata[7:0]);
          end
        default: st_d.in_service = st_q.in_service;
      endcase
    end else if (st_q.ack && req.read && st_q.vec_hit && st_q.nest_en) begin
      // Side effect of the vector read, taken on its acknowledge.
      st_d.in_service[st_q.vec_level] = 1'b1;
    end
    if (!reset_n) begin
      st_d = '0;
    end
  end

  // Single register for all state.
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign irq_request = hit;
  assign irq_index = win_index;
  assign irq_nesting_on = st_q.nest_en;

  property p_wait_one;
    @(posedge mclk) disable iff (!reset_n)
      ((avs_read || avs_write) && !st_q.ack) |=>
      ((avs_read || avs_write) -> !avs_waitrequest);
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("Access not acknowledged after one wait cycle.");

  property p_vec_base;
    @(posedge mclk) disable iff (!reset_n)
      (avs_read && avs_address == VIPB_ADDR_VEC && !st_q.ack) |=>
      (avs_readdata[22:7] == st_q.base && avs_readdata[31:23] == 9'h0);
  endproperty
  a_vec_base: assert property (p_vec_base)
    else $error("Vector word does not carry the base.");

  property p_vec_index;
    @(posedge mclk) disable iff (!reset_n)
      (avs_read && avs_address == VIPB_ADDR_VEC && !st_q.ack) |=>
      (avs_readdata[6:2] == $past(win_index) && avs_readdata[1:0] == 2'b00);
  endproperty
  a_vec_index: assert property (p_vec_index)
    else $error("Vector word index differs from the winner.");

  property p_prio0_low;
    @(posedge mclk) disable iff (!reset_n)
      st_q.ack && $past(avs_read) &&
      $past(avs_address) == VIPB_ADDR_PRIO0 |->
      avs_readdata[3:0] == 4'h0;
  endproperty
  a_prio0_low: assert property (p_prio0_low)
    else $error("Source 0 bits of the first register not zero.");

  property p_prio3_resv;
    @(posedge mclk) disable iff (!reset_n)
      st_q.ack && $past(avs_read) &&
      $past(avs_address) == VIPB_ADDR_PRIO3 |->
      avs_readdata[31:7] == 25'h0 && !avs_readdata[3];
  endproperty
  a_prio3_resv: assert property (p_prio3_resv)
    else $error("Reserved bits of the fourth register not zero.");

  property p_prio1_write;
    @(posedge mclk) disable iff (!reset_n)
      (avs_write && st_q.ack && avs_address == VIPB_ADDR_PRIO1 &&
       avs_byteenable == 4'hf) |=>
      st_q.prio[1] == ($past(avs_writedata) & VIPB_MASK_PRIO1);
  endproperty
  a_prio1_write: assert property (p_prio1_write)
    else $error("Second priority register write not stored.");

  property p_vec_sets_insvc;
    @(posedge mclk) disable iff (!reset_n)
      (avs_read && st_q.ack && st_q.vec_hit && st_q.nest_en) |=>
      st_q.in_service[$past(st_q.vec_level)];
  endproperty
  a_vec_sets_insvc: assert property (p_vec_sets_insvc)
    else $error("Vector read did not set the in-service bit.");

  property p_flat_no_insvc;
    @(posedge mclk) disable iff (!reset_n)
      (!st_q.nest_en && !(avs_write && avs_address == VIPB_ADDR_INSVC)) |=>
      $stable(st_q.in_service);
  endproperty
  a_flat_no_insvc: assert property (p_flat_no_insvc)
    else $error("In-service bits changed with nesting off.");

  property p_clear_one;
    @(posedge mclk) disable iff (!reset_n)
      (avs_write && st_q.ack && avs_address == VIPB_ADDR_INSVC &&
       avs_byteenable[0] && avs_writedata[7:0] == 8'hff) |=>
      st_q.in_service == ($past(st_q.in_service) & ~$past(lowest_insvc));
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("In-service clear removed other than the top bit.");

  property p_prio0_write;
    @(posedge mclk) disable iff (!reset_n)
      (avs_write && st_q.ack && avs_address == VIPB_ADDR_PRIO0 &&
       avs_byteenable == 4'hf) |=>
      st_q.prio[0] == ($past(avs_writedata) & VIPB_MASK_PRIO0);
  endproperty
  a_prio0_write: assert property (p_prio0_write)
    else $error("First priority register write not stored.");

  property p_prio2_write;
    @(posedge mclk) disable iff (!reset_n)
      (avs_write && st_q.ack && avs_address == VIPB_ADDR_PRIO2 &&
       avs_byteenable == 4'hf) |=>
      st_q.prio[2] == ($past(avs_writedata) & VIPB_MASK_PRIO2);
  endproperty
  a_prio2_write: assert property (p_prio2_write)
    else $error("Third priority register write not stored.");

  property p_prio3_write;
    @(posedge mclk) disable iff (!reset_n)
      (avs_write && st_q.ack && avs_address == VIPB_ADDR_PRIO3 &&
       avs_byteenable == 4'hf) |=>
      st_q.prio[3] == ($past(avs_writedata) & VIPB_MASK_PRIO3);
  endproperty
  a_prio3_write: assert property (p_prio3_write)
    else $error("Fourth priority register write not stored.");

  property p_nest_write;
    @(posedge mclk) disable iff (!reset_n)
      (avs_write && st_q.ack && avs_address == VIPB_ADDR_NEST &&
       avs_byteenable[0]) |=>
      irq_nesting_on == $past(avs_writedata[VIPB_NEST_BIT]);
  endproperty
  a_nest_write: assert property (p_nest_write)
    else $error("Nesting bit write not stored.");

  // Reserved bits are checked against a fixed pattern, not the masks.
  property p_prio12_resv;
    @(posedge mclk) disable iff (!reset_n)
      st_q.ack && $past(avs_read) &&
      ($past(avs_address) == VIPB_ADDR_PRIO1 ||
       $past(avs_address) == VIPB_ADDR_PRIO2) |->
      (avs_readdata & 32'h88888888) == 32'h0;
  endproperty
  a_prio12_resv: assert property (p_prio12_resv)
    else $error("Reserved bits of a priority register not zero.");

  property p_base_read;
    @(posedge mclk) disable iff (!reset_n)
      st_q.ack && $past(avs_read) &&
      $past(avs_address) == VIPB_ADDR_BASE |->
      avs_readdata[31:16] == 16'h0000;
  endproperty
  a_base_read: assert property (p_base_read)
    else $error("Upper half of the base register not zero.");

  // Without nesting the lowest active index must win, whatever the levels.
  property p_flat_lowest;
    @(posedge mclk) disable iff (!reset_n)
      (!irq_nesting_on && irq_active != 28'h0) |->
      (irq_request && irq_active[irq_index] &&
       (irq_active & ((28'h1 << irq_index) - 28'h1)) == 28'h0);
  endproperty
  a_flat_lowest: assert property (p_flat_lowest)
    else $error("Without nesting the lowest active index did not win.");

  property p_none_idle;
    @(posedge mclk) disable iff (!reset_n)
      irq_active == 28'h0 |-> !irq_request && irq_index == 5'h0;
  endproperty
  a_none_idle: assert property (p_none_idle)
    else $error("Request or index shown with no source active.");

  // No in-service bit may sit at or above the winner's priority.
  property p_nest_unblocked;
    @(posedge mclk) disable iff (!reset_n)
      (st_q.nest_en && hit) |->
      (st_q.in_service & ((8'h02 << win_level) - 8'h01)) == 8'h00;
  endproperty
  a_nest_unblocked: assert property (p_nest_unblocked)
    else $error("Winner lies at or below an in-service level.");

  property p_vec_range;
    @(posedge mclk) disable iff (!reset_n)
      (avs_read && avs_address == VIPB_ADDR_VEC && !st_q.ack) |=>
      avs_readdata[6:2] < 5'h1c;
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("Vector source index beyond the last source.");

endmodule

// ### verification/vipb_src_model.sv
`timescale 1ns/1ps
// Stands in for the peripherals that raise requests towards the bank.
module vipb_src_model
  import vipb_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Sources to raise, and the requests shown to the bank.
  input wire logic [VIPB_NUM_SRC-1:0] raise,
  output logic [VIPB_NUM_SRC-1:0] irq_active
);
  // Registered, as a peripheral flag is, so requests never glitch.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_active <= '0;
    end else begin
      irq_active <= raise;
    end
  end
endmodule

// ### verification/test_vectored_irq_priority_bank.sv
`timescale 1ns/1ps
module test_vectored_irq_priority_bank;
  import vipb_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] avs_address = 32'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [VIPB_NUM_SRC-1:0] raise = '0;
  logic [VIPB_NUM_SRC-1:0] irq_active;
  logic irq_request;
  vipb_index_t irq_index;
  logic irq_nesting_on;
  logic [31:0] exp_q[$];
  logic [31:0] adr[4] = '{VIPB_ADDR_PRIO0, VIPB_ADDR_PRIO1,
                          VIPB_ADDR_PRIO2, VIPB_ADDR_PRIO3};
  logic [31:0] msk[4] = '{VIPB_MASK_PRIO0, VIPB_MASK_PRIO1,
                          VIPB_MASK_PRIO2, VIPB_MASK_PRIO3};
  logic [31:0] d;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 60289;

  vipb_bank i_vipb_bank (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq_active(irq_active), .irq_request(irq_request),
    .irq_index(irq_index), .irq_nesting_on(irq_nesting_on));
  vipb_src_model i_vipb_src_model (.mclk(mclk), .reset_n(reset_n),
    .raise(raise), .irq_active(irq_active));

  // Clock at 50 MHz.
  initial begin
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The request is held until waitrequest is sampled low at an edge.
  task automatic bus_write(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= v;
    @(posedge mclk iff !avs_waitrequest);
    avs_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge mclk);
    avs_read <= 1'b1;
    avs_address <= a;
    @(posedge mclk iff !avs_waitrequest);
    avs_read <= 1'b0;
  endtask

  // Read data are taken at the same edge that ends the wait.
  always @(posedge mclk) begin
    if (avs_read && !avs_waitrequest) begin
      check(avs_readdata, exp_q.pop_front());
    end
  end

  // Cuts a hang short; the whole run needs well under 2000 cycles.
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) bus_read(adr[i], VIPB_RESET_VALUE);
    bus_read(32'hffff0040, 32'h0);
    $display("reset and unmapped test done");
    // All ones shows which bits hold levels; reserved bits stay zero.
    for (int i = 0; i < 4; i++) begin
      bus_write(adr[i], 32'hffffffff);
      bus_read(adr[i], msk[i]);
    end
    for (int k = 0; k < 12; k++) begin
      d = $random(seed);
      bus_write(adr[k % 4], d);
      bus_read(adr[k % 4], d & msk[k % 4]);
    end
    // Only byte lane 2 is written; the other fields keep their levels.
    bus_write(VIPB_ADDR_PRIO2, 32'h12345670);
    avs_byteenable <= 4'h4;
    bus_write(VIPB_ADDR_PRIO2, 32'hffffffff);
    avs_byteenable <= 4'hf;
    bus_read(VIPB_ADDR_PRIO2, 32'h12775670);
    $display("field layout test done");
    // Timer 2 at level 1, converter at level 0, the rest of the first two registers at level 7.
    bus_write(VIPB_ADDR_PRIO0, 32'h77717770);
    bus_write(VIPB_ADDR_PRIO1, 32'h77777770);
    bus_write(VIPB_ADDR_BASE, 32'h00001234);
    raise <= 28'h0000110;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({31'h0, irq_request}, 32'h1);
    check({27'h0, irq_index}, 32'h4);
    bus_write(VIPB_ADDR_NEST, 32'h00000001);
    @(negedge mclk);
    check({31'h0, irq_nesting_on}, 32'h1);
    check({27'h0, irq_index}, 32'h8);
    bus_read(VIPB_ADDR_NEST, 32'h00000001);
    bus_read(VIPB_ADDR_BASE, 32'h00001234);
    // Vector read only with nesting on and a source pending.
    bus_read(VIPB_ADDR_VEC, (32'h1234 << 7) | (32'h8 << 2));
    bus_read(VIPB_ADDR_INSVC, 32'h00000001);
    @(negedge mclk);
    check({31'h0, irq_request}, 32'h0);
    bus_write(VIPB_ADDR_INSVC, 32'h000000ff);
    bus_read(VIPB_ADDR_INSVC, 32'h0);
    @(negedge mclk);
    check({31'h0, irq_request}, 32'h1);
    // Level 1 is taken first, then level 0 nests above it.
    @(posedge mclk);
    raise <= 28'h0000010;
    repeat (2) @(posedge mclk);
    bus_read(VIPB_ADDR_VEC, (32'h1234 << 7) | (32'h4 << 2));
    raise <= 28'h0000110;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({27'h0, irq_index}, 32'h8);
    bus_read(VIPB_ADDR_VEC, (32'h1234 << 7) | (32'h8 << 2));
    bus_read(VIPB_ADDR_INSVC, 32'h00000003);
    // Each clear removes only the highest-priority in-service bit.
    bus_write(VIPB_ADDR_INSVC, 32'h000000ff);
    bus_read(VIPB_ADDR_INSVC, 32'h00000002);
    bus_write(VIPB_ADDR_INSVC, 32'h000000ff);
    bus_read(VIPB_ADDR_INSVC, 32'h0);
    $display("vector and nesting test done");
    repeat (2) @(posedge mclk);
    test_done();
  end
endmodule
